// ===== lcd_pkg.sv
/*
  shared constants, types and command decoding for the lcd host interface
  decoder. assumes a single sys_clk domain; every pin is synchronised by
  the user of this package before it is decoded.
*/
package lcd_pkg;

  // display memory geometry
  localparam int ROWS      = 65;
  localparam int COLS      = 132;
  localparam int PAGES     = 9;
  localparam int MEM_DEPTH = PAGES * COLS;
  localparam int IDX_W     = 11;
  localparam logic [3:0] LAST_PAGE = 4'h8;
  localparam logic [7:0] LAST_COL  = 8'h83;

  // positions inside the synchronised pin vector
  localparam int SYNC_W  = 15;
  localparam int P_DB    = 0;
  localparam int P_RW    = 8;
  localparam int P_E     = 9;
  localparam int P_RS    = 10;
  localparam int P_STYLE = 11;
  localparam int P_KIND  = 12;
  localparam int P_CS2   = 13;
  localparam int P_CSN   = 14;

  // serial pins on the data bus
  localparam int SER_DATA_BIT = 7;
  localparam int SER_CLK_BIT  = 6;
  localparam logic [2:0] SER_LAST_BIT = 3'h7;

  // status byte bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_ADC  = 6;
  localparam int ST_ON   = 5;
  localparam int ST_RST  = 4;

  // command opcodes
  localparam logic [6:0] OP_DISPLAY = 7'h57;
  localparam logic [6:0] OP_ADC     = 7'h50;
  localparam logic [6:0] OP_REVERSE = 7'h53;
  localparam logic [6:0] OP_ALL_ON  = 7'h52;
  localparam logic [1:0] OP_START   = 2'h1;
  localparam logic [3:0] OP_PAGE    = 4'hb;
  localparam logic [3:0] OP_COL_HI  = 4'h1;
  localparam logic [3:0] OP_COL_LO  = 4'h0;

  // values after reset, and the full buffer count
  localparam logic [5:0] START_RST = 6'h00;
  localparam logic [3:0] PAGE_RST  = 4'h0;
  localparam logic [7:0] COL_RST   = 8'h00;
  localparam logic [7:0] BYTE_RST  = 8'h00;
  localparam logic [1:0] COUNT_RST = 2'h0;
  localparam logic [1:0] COUNT_MAX = 2'h2;

  typedef struct packed {
    logic       is_data;
    logic [7:0] value;
  } host_byte_t;

  typedef struct packed {
    logic panel_on;
    logic seg_reverse;
    logic invert;
    logic all_on;
  } display_mode_t;

  localparam display_mode_t MODE_RST = '0;

  typedef enum {
    IF_SERIAL,
    IF_6800,
    IF_8080
  } if_mode_t;

  typedef enum {
    CMD_OTHER,
    CMD_DISPLAY,
    CMD_ADC,
    CMD_REVERSE,
    CMD_ALL_ON,
    CMD_START,
    CMD_PAGE,
    CMD_COL_HI,
    CMD_COL_LO
  } cmd_t;

  function automatic cmd_t decode_command(input logic [7:0] b);
    cmd_t c;
    c = CMD_OTHER;
    if (b[7:1] == OP_DISPLAY) c = CMD_DISPLAY;
    else if (b[7:1] == OP_ADC) c = CMD_ADC;
    else if (b[7:1] == OP_REVERSE) c = CMD_REVERSE;
    else if (b[7:1] == OP_ALL_ON) c = CMD_ALL_ON;
    else if (b[7:6] == OP_START) c = CMD_START;
    else if (b[7:4] == OP_PAGE) c = CMD_PAGE;
    else if (b[7:4] == OP_COL_HI) c = CMD_COL_HI;
    else if (b[7:4] == OP_COL_LO) c = CMD_COL_LO;
    return c;
  endfunction

endpackage

// ===== two_entry_buffer.sv
/*
  two-entry first-in first-out buffer for host bytes.
  assumes a single clock; the drain side may hold out_ready low for any time.
*/
module two_entry_buffer (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               rstn,
  // filling side
  input  wire logic               in_valid,
  output logic                    in_ready,
  input  wire lcd_pkg::host_byte_t in_data,
  // draining side
  output logic                    out_valid,
  input  wire logic               out_ready,
  output lcd_pkg::host_byte_t     out_data
);

  lcd_pkg::host_byte_t slot_q [2];
  logic       wr_ptr_q;
  logic       rd_ptr_q;
  logic [1:0] count_q;
  logic       push;
  logic       pop;

  assign in_ready  = (count_q != lcd_pkg::COUNT_MAX);
  assign out_valid = (count_q != lcd_pkg::COUNT_RST);
  assign out_data  = slot_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge sys_clk) begin
    if (push) begin
      slot_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      count_q  <= lcd_pkg::COUNT_RST;
    end else begin
      if (push) wr_ptr_q <= !wr_ptr_q;
      if (pop) rd_ptr_q <= !rd_ptr_q;
      if (push && !pop) count_q <= count_q + 2'h1;
      else if (pop && !push) count_q <= count_q - 2'h1;
    end
  end

endmodule

// ===== lcd_host_interface_decoder.sv
/*
  host interface and command decoder of a dot-matrix lcd controller:
  chip select, serial and two parallel bus styles, busy flag, bus holder
  reads, display memory and command decoding.
  assumes all host pins are asynchronous to sys_clk and held stable for
  several sys_clk periods; reset_in_progress_flag comes from sys_clk logic.
*/
// Functional notes
// - memory of 65 by 132 dots, one lights
// - accesses only with both chip selects active
// - otherwise strobes ignored, data bus released
// - deselect clears serial shifter and counter
// - interface pin picks serial, style pin parallel
// - serial uses line seven data, six clock
// - shift on rising clock, eighth bit completes byte
// - select line high data, low command
// - serial path is write only
// - busy on bit seven, only status then; up to two writes made during reset still queue
// - written byte moves to memory automatically
// - first read after address is dummy
// - display command switches panel on or off
// - start line command loads six bits
// - page and column nibble address commands
// - status read returns four flags, low zero
// - data select writes and reads memory
// - segment mapping ascending or reversed
// - pixel polarity normal or inverted
// - all dots on or normal display
module lcd_host_interface_decoder (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // host pins
  input  wire logic       chip_select_low_active_n,
  input  wire logic       chip_select_high_active,
  input  wire logic       interface_kind_select,
  input  wire logic       parallel_style_select,
  input  wire logic       data_command_select,
  input  wire logic       enable_or_read_strobe,
  input  wire logic       rw_or_write_strobe,
  input  wire logic [7:0] data_bus_in,
  output logic      [7:0] data_bus_out,
  output logic            data_bus_oe_n,
  // device state
  input  wire logic       reset_in_progress_flag,
  output logic            busy_flag,
  output logic            panel_on_flag,
  output logic            seg_reverse_flag,
  output logic            polarity_invert_bit,
  output logic            all_dots_on_bit,
  output logic      [5:0] start_line_field,
  output logic      [3:0] page_address_field,
  output logic      [7:0] column_address_field,
  // display scan port
  input  wire logic [3:0] scan_page,
  input  wire logic [7:0] scan_col,
  output logic      [7:0] scan_data
);

  function automatic logic in_range(input logic [3:0] pg,
                                    input logic [7:0] cl);
    in_range = (pg <= lcd_pkg::LAST_PAGE) && (cl <= lcd_pkg::LAST_COL);
  endfunction

  function automatic logic [lcd_pkg::IDX_W-1:0] mem_index(
    input logic [3:0] pg,
    input logic [7:0] cl);
    mem_index = lcd_pkg::IDX_W'(int'(pg) * lcd_pkg::COLS + int'(cl));
  endfunction

  // pin synchroniser
  logic [lcd_pkg::SYNC_W-1:0] pins_raw;
  logic [lcd_pkg::SYNC_W-1:0] sync1_q;
  logic [lcd_pkg::SYNC_W-1:0] sync2_q;

  assign pins_raw = {chip_select_low_active_n, chip_select_high_active,
                     interface_kind_select, parallel_style_select,
                     data_command_select, enable_or_read_strobe,
                     rw_or_write_strobe, data_bus_in};

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end

  wire [7:0] db_s    = sync2_q[lcd_pkg::P_DB +: 8];
  wire       rw_s    = sync2_q[lcd_pkg::P_RW];
  wire       e_s     = sync2_q[lcd_pkg::P_E];
  wire       rs_s    = sync2_q[lcd_pkg::P_RS];
  wire       style_s = sync2_q[lcd_pkg::P_STYLE];
  wire       kind_s  = sync2_q[lcd_pkg::P_KIND];
  wire       cs2_s   = sync2_q[lcd_pkg::P_CS2];
  wire       csn_s   = sync2_q[lcd_pkg::P_CSN];

  // interface selection
  lcd_pkg::if_mode_t if_mode;
  wire selected = !csn_s && cs2_s;

  assign if_mode = !kind_s ? lcd_pkg::IF_SERIAL :
                   style_s ? lcd_pkg::IF_6800 : lcd_pkg::IF_8080;

  wire is_serial = (if_mode == lcd_pkg::IF_SERIAL);
  wire is_6800   = (if_mode == lcd_pkg::IF_6800);
  wire par_sel   = selected && !is_serial;

  // strobe edge detection
  logic e_prev_q;
  logic rw_prev_q;
  logic sclk_prev_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      e_prev_q    <= 1'b0;
      rw_prev_q   <= 1'b1;
      sclk_prev_q <= 1'b0;
    end else begin
      e_prev_q    <= e_s;
      rw_prev_q   <= rw_s;
      sclk_prev_q <= db_s[lcd_pkg::SER_CLK_BIT];
    end
  end

  wire e_fall = e_prev_q && !e_s;
  wire e_rise = !e_prev_q && e_s;
  wire w_rise = !rw_prev_q && rw_s;

  wire par_rd_active = par_sel && (is_6800 ? (e_s && rw_s) : !e_s);
  wire par_wr_end    = par_sel && (is_6800 ? (e_fall && !rw_s) : w_rise);
  wire par_rd_end    = par_sel && (is_6800 ? (e_fall && rw_s) : e_rise);

  // serial shifter
  logic [7:0] shift_q;
  logic [2:0] bit_cnt_q;

  wire sclk_rise = selected && is_serial && !sclk_prev_q &&
                   db_s[lcd_pkg::SER_CLK_BIT];
  wire [7:0] shift_d = {shift_q[6:0], db_s[lcd_pkg::SER_DATA_BIT]};
  wire ser_done = sclk_rise && (bit_cnt_q == lcd_pkg::SER_LAST_BIT);

  always_ff @(posedge sys_clk) begin
    if (!rstn || !selected) begin
      shift_q   <= lcd_pkg::BYTE_RST;
      bit_cnt_q <= 3'h0;
    end else if (sclk_rise) begin
      shift_q   <= shift_d;
      bit_cnt_q <= bit_cnt_q + 3'h1;
    end
  end

  // host byte buffer
  lcd_pkg::host_byte_t wr_byte;
  lcd_pkg::host_byte_t cmd_byte;
  logic buf_in_ready;
  logic buf_out_valid;

  assign wr_byte.is_data = rs_s;
  assign wr_byte.value   = is_serial ? shift_d : db_s;

  wire wr_valid = (par_wr_end && !rw_prev_q) || ser_done;
  wire drain_ok = !reset_in_progress_flag;
  wire busy     = !buf_in_ready || reset_in_progress_flag;

  two_entry_buffer u_buffer (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (wr_valid),
    .in_ready  (buf_in_ready),
    .in_data   (wr_byte),
    .out_valid (buf_out_valid),
    .out_ready (drain_ok),
    .out_data  (cmd_byte)
  );

  // command decode
  lcd_pkg::cmd_t cmd;
  wire commit   = buf_out_valid && drain_ok;
  wire cmd_take = commit && !cmd_byte.is_data;
  wire dat_take = commit && cmd_byte.is_data;
  wire rd_take  = par_rd_end && rs_s && !busy &&
                  !buf_out_valid;

  assign cmd = lcd_pkg::decode_command(cmd_byte.value);

  // state registers
  lcd_pkg::display_mode_t mode_q;
  lcd_pkg::display_mode_t mode_d;
  logic [5:0] start_q;
  logic [5:0] start_d;
  logic [3:0] page_q;
  logic [3:0] page_d;
  logic [7:0] col_q;
  logic [7:0] col_d;
  logic [7:0] holder_q;

  wire [7:0] col_next = (col_q >= lcd_pkg::LAST_COL) ? col_q :
                        col_q + 8'h01;
  wire       addr_ok  = in_range(page_q, col_q);
  wire [lcd_pkg::IDX_W-1:0] host_idx = mem_index(page_q, col_q);

  always_comb begin
    mode_d  = mode_q;
    start_d = start_q;
    page_d  = page_q;
    col_d   = col_q;
    if (cmd_take) begin
      unique case (cmd)
        lcd_pkg::CMD_DISPLAY: mode_d.panel_on = cmd_byte.value[0];
        lcd_pkg::CMD_ADC: mode_d.seg_reverse = cmd_byte.value[0];
        lcd_pkg::CMD_REVERSE: mode_d.invert = cmd_byte.value[0];
        lcd_pkg::CMD_ALL_ON: mode_d.all_on = cmd_byte.value[0];
        lcd_pkg::CMD_START:   start_d = cmd_byte.value[5:0];
        lcd_pkg::CMD_PAGE:    page_d  = cmd_byte.value[3:0];
        lcd_pkg::CMD_COL_HI:  col_d   = {cmd_byte.value[3:0], col_q[3:0]};
        lcd_pkg::CMD_COL_LO:  col_d   = {col_q[7:4], cmd_byte.value[3:0]};
        lcd_pkg::CMD_OTHER:   col_d   = col_q;
      endcase
    end else if (dat_take || rd_take) begin
      col_d = col_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      mode_q  <= lcd_pkg::MODE_RST;
      start_q <= lcd_pkg::START_RST;
      page_q  <= lcd_pkg::PAGE_RST;
      col_q   <= lcd_pkg::COL_RST;
    end else begin
      mode_q  <= mode_d;
      start_q <= start_d;
      page_q  <= page_d;
      col_q   <= col_d;
    end
  end

  // display memory, one byte per page column
  logic [7:0] mem [lcd_pkg::MEM_DEPTH];

  always_ff @(posedge sys_clk) begin
    if (dat_take && addr_ok) begin
      mem[host_idx] <= cmd_byte.value;
    end
  end

  // bus holder: each data read hands out the previous fetch
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      holder_q <= lcd_pkg::BYTE_RST;
    end else if (rd_take) begin
      holder_q <= addr_ok ? mem[host_idx] : lcd_pkg::BYTE_RST;
    end
  end

  // status byte from live state
  logic [7:0] status_byte;

  always_comb begin
    status_byte                   = 8'h00;
    status_byte[lcd_pkg::ST_BUSY] = busy;
    status_byte[lcd_pkg::ST_ADC]  = mode_q.seg_reverse;
    status_byte[lcd_pkg::ST_ON]   = mode_q.panel_on;
    status_byte[lcd_pkg::ST_RST]  = reset_in_progress_flag;
  end

  // read data output, parallel modes only
  logic [7:0] db_out_q;
  logic       db_oe_n_q;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      db_out_q  <= lcd_pkg::BYTE_RST;
      db_oe_n_q <= 1'b1;
    end else begin
      db_out_q  <= rs_s ? holder_q : status_byte;
      db_oe_n_q <= !par_rd_active;
    end
  end

  // scan read with segment mapping and pixel effects
  logic [7:0] scan_q;

  wire [7:0] scan_seg = mode_q.seg_reverse ?
                        lcd_pkg::LAST_COL - scan_col : scan_col;
  wire       scan_ok  = in_range(scan_page, scan_seg);
  wire [lcd_pkg::IDX_W-1:0] scan_idx = mem_index(scan_page, scan_seg);
  wire [7:0] scan_raw = scan_ok ? mem[scan_idx] : lcd_pkg::BYTE_RST;
  wire [7:0] scan_pix = mode_q.all_on ? 8'hff :
                        scan_raw ^ {8{mode_q.invert}};

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      scan_q <= lcd_pkg::BYTE_RST;
    end else begin
      scan_q <= scan_pix;
    end
  end

  // outputs
  assign data_bus_out         = db_out_q;
  assign data_bus_oe_n        = db_oe_n_q;
  assign busy_flag            = busy;
  assign panel_on_flag        = mode_q.panel_on;
  assign seg_reverse_flag     = mode_q.seg_reverse;
  assign polarity_invert_bit  = mode_q.invert;
  assign all_dots_on_bit      = mode_q.all_on;
  assign start_line_field     = start_q;
  assign page_address_field   = page_q;
  assign column_address_field = col_q;
  assign scan_data            = scan_q;

endmodule

// ===== lcd_host_properties.sv
/*
  concurrent checks on the decoder's pins, flags and status byte.
  assumes a bind from the bench and host pins held at least 4 cycles.
*/
module lcd_host_properties (
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // host pins
  input wire logic       chip_select_low_active_n,
  input wire logic       chip_select_high_active,
  input wire logic       interface_kind_select,
  input wire logic       parallel_style_select,
  input wire logic       data_command_select,
  input wire logic       enable_or_read_strobe,
  input wire logic       rw_or_write_strobe,
  input wire logic [7:0] data_bus_in,
  input wire logic [7:0] data_bus_out,
  input wire logic       data_bus_oe_n,
  // device state
  input wire logic       reset_in_progress_flag,
  input wire logic       busy_flag,
  input wire logic       panel_on_flag,
  input wire logic       seg_reverse_flag,
  input wire logic       polarity_invert_bit,
  input wire logic       all_dots_on_bit,
  input wire logic [5:0] start_line_field,
  input wire logic [3:0] page_address_field
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire logic sel = !chip_select_low_active_n && chip_select_high_active;
  wire logic p80 = sel && interface_kind_select && !parallel_style_select;
  // accepted 8080 command write, sustained 8080 status read
  sequence wr_cmd;
    p80 && !data_command_select && $rose(rw_or_write_strobe) && !busy_flag;
  endsequence
  sequence stat_rd;
    (p80 && !data_command_select && !enable_or_read_strobe) [*4];
  endsequence
  property sets(logic [7:0] code, logic flag);
    wr_cmd ##0 data_bus_in == code |-> ##[1:8] flag;
  endproperty
  property start_load;
    logic [5:0] v;
    (wr_cmd ##0 (data_bus_in[7:6] == 2'h1, v = data_bus_in[5:0]))
      |-> ##[1:8] start_line_field == v;
  endproperty
  property page_load;
    logic [3:0] v;
    (wr_cmd ##0 (data_bus_in[7:4] == 4'hb, v = data_bus_in[3:0]))
      |-> ##[1:8] page_address_field == v;
  endproperty
  desel_release_a: assert property (!sel [*4] |-> data_bus_oe_n)
    else $error("bus driven while deselected");
  serial_quiet_a: assert property (
    !interface_kind_select [*4] |-> data_bus_oe_n)
    else $error("bus driven in serial mode");
  busy_reset_a: assert property (
    reset_in_progress_flag |-> busy_flag)
    else $error("busy low during reset");
  status_read_a: assert property (
    stat_rd |-> !data_bus_oe_n && data_bus_out[3:0] == 4'h0 &&
    data_bus_out[7] == $past(busy_flag) &&
    data_bus_out[6] == $past(seg_reverse_flag) &&
    data_bus_out[5] == $past(panel_on_flag) &&
    data_bus_out[4] == $past(reset_in_progress_flag))
    else $error("status byte wrong");
  panel_on_a: assert property (sets(8'haf, panel_on_flag))
    else $error("panel not switched on");
  seg_rev_a: assert property (sets(8'ha1, seg_reverse_flag))
    else $error("segment order not reversed");
  invert_on_a: assert property (sets(8'ha7, polarity_invert_bit))
    else $error("polarity not inverted");
  all_on_a: assert property (sets(8'ha5, all_dots_on_bit))
    else $error("all dots not on");
  start_line_a: assert property (start_load)
    else $error("start line not loaded");
  page_set_a: assert property (page_load)
    else $error("page not loaded");
endmodule

// ===== host_model.sv
/*
  host processor model driving the decoder's pins in serial, 6800 or
  8080 style; assumes the bench calls its tasks on an 8 ns clock.
*/
module host_model (
  // clock
  input  wire logic       sys_clk,
  // pins towards the device
  output logic            sel_n,
  output logic            cs_hi,
  output logic            kind,
  output logic            style,
  output logic            rs,
  output logic            e_rd,
  output logic            rw_wr,
  output logic      [7:0] bus,
  // level on the data wires
  input  wire logic [7:0] level
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {sel_n, cs_hi, kind, style, rs, e_rd, rw_wr} = 7'h53;
    bus = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chips(input logic n, input logic h);
    {sel_n, cs_hi} = {n, h};
    tick(4);
  endtask
  // idle strobes follow the bus style
  task automatic mode(input logic k, input logic s);
    {kind, style, e_rd, rw_wr} = {k, s, !s, 1'b1};
    tick(4);
  endtask
  // msb first, clock still between frames
  task automatic shift(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) begin
      bus = {b[i], 1'b0, ~bus[5:0]};
      tick(10);
      bus[6] = 1'b1;
      tick(10);
    end
    bus = {~bus[7], 1'b0, bus[5:0]};
  endtask
  // one byte, polling skipped, cycle time kept
  task automatic write(input logic dc, input logic [7:0] b);
    rs = dc;
    if (kind) bus = b;
    tick(4);
    if (!kind) shift(b, 8);
    else if (style) begin
      rw_wr = 1'b0;
      e_rd = 1'b1;
      tick(4);
      e_rd = 1'b0;
      tick(4);
      rw_wr = 1'b1;
    end else begin
      rw_wr = 1'b0;
      tick(4);
      rw_wr = 1'b1;
    end
    tick(3);
    if (kind) bus = ~b;
    tick(1);
  endtask
  task automatic read(input logic dc, output logic [7:0] q);
    rs = dc;
    tick(2);
    e_rd = style;
    tick(6);
    q = level;
    e_rd = !style;
    tick(6);
  endtask
endmodule

// ===== testbench.sv
/*
  self-checking bench for the lcd host interface decoder and its host
  model; assumes the package, design, model and checker compiled first.
*/
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      n_errors++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
  end
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic            sys_clk;
  logic            rstn;
  logic            rip;
  logic      [3:0] scan_page;
  logic      [7:0] scan_col;
  logic      [7:0] q;
  wire logic       sel_n, cs_hi, kind, style, rs, e_rd, rw_wr;
  wire logic       oe_n, busy, on, segr, inv, allon;
  wire logic [7:0] host_bus, dout, scan_data, col, level;
  wire logic [5:0] start;
  wire logic [3:0] page;
  int              n_errors = 0;
  int              checked = 0;
  assign level = oe_n ? host_bus : dout;
  host_model u_host (.sys_clk, .sel_n, .cs_hi, .kind, .style, .rs,
    .e_rd, .rw_wr, .bus(host_bus), .level);
  lcd_host_interface_decoder u_dut (
    .sys_clk, .rstn,
    .chip_select_low_active_n(sel_n),
    .chip_select_high_active(cs_hi),
    .interface_kind_select(kind),
    .parallel_style_select(style),
    .data_command_select(rs),
    .enable_or_read_strobe(e_rd),
    .rw_or_write_strobe(rw_wr),
    .data_bus_in(level), .data_bus_out(dout), .data_bus_oe_n(oe_n),
    .reset_in_progress_flag(rip), .busy_flag(busy),
    .panel_on_flag(on), .seg_reverse_flag(segr),
    .polarity_invert_bit(inv), .all_dots_on_bit(allon),
    .start_line_field(start), .page_address_field(page),
    .column_address_field(col),
    .scan_page, .scan_col, .scan_data);
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic test_done();
    if (n_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] b);
    u_host.write(1'b0, b);
  endtask
  task automatic dat(input logic [7:0] b);
    u_host.write(1'b1, b);
  endtask
  task automatic scan(input logic [7:0] c, input logic [7:0] e);
    {scan_page, scan_col} = {4'h2, c};
    u_host.tick(2);
    `CHK("scan", e, scan_data)
  endtask
  task automatic t_commands();
    u_host.chips(1'b0, 1'b1);
    `CHK("flags", 4'h0, {on, segr, inv, allon})
    cmd(8'haf);
    cmd(8'ha1);
    cmd(8'ha7);
    cmd(8'ha5);
    `CHK("flags", 4'hf, {on, segr, inv, allon})
    cmd(8'h5a);
    cmd(8'hb3);
    cmd(8'h12);
    cmd(8'h05);
    `CHK("start", 6'h1a, start)
    `CHK("addr", 12'h325, {page, col})
    u_host.read(1'b0, q);
    `CHK("status", 8'h60, q)
    cmd(8'hae);
    cmd(8'ha0);
    cmd(8'ha6);
    cmd(8'ha4);
    `CHK("flags", 4'h0, {on, segr, inv, allon})
    u_host.read(1'b0, q);
    `CHK("status", 8'h00, q)
  endtask
  task automatic t_data();
    u_host.mode(1'b1, 1'b1);
    cmd(8'hb2);
    cmd(8'h11);
    cmd(8'h00);
    dat(8'h11);
    dat(8'h22);
    dat(8'h33);
    `CHK("col", 8'h13, col)
    cmd(8'h11);
    cmd(8'h00);
    u_host.read(1'b1, q);
    u_host.read(1'b1, q);
    `CHK("rd0", 8'h11, q)
    u_host.read(1'b1, q);
    `CHK("rd1", 8'h22, q)
    scan(8'h12, 8'h33);
    cmd(8'ha1);
    scan(8'h71, 8'h33);
    cmd(8'ha0);
    cmd(8'ha7);
    scan(8'h12, 8'hcc);
    cmd(8'ha6);
    cmd(8'ha5);
    scan(8'h12, 8'hff);
    cmd(8'ha4);
  endtask
  task automatic t_deselect();
    u_host.chips(1'b0, 1'b0);
    cmd(8'haf);
    u_host.chips(1'b1, 1'b1);
    cmd(8'haf);
    `CHK("panel", 1'b0, on)
    u_host.read(1'b0, q);
    `CHK("float", 8'h50, q)
    u_host.chips(1'b0, 1'b1);
  endtask
  task automatic t_busy();
    rip = 1'b1;
    cmd(8'haf);
    `CHK("panel", 1'b0, on)
    u_host.read(1'b0, q);
    `CHK("status", 8'h90, q)
    `CHK("busy", 1'b1, busy)
    rip = 1'b0;
    u_host.tick(8);
    `CHK("panel", 1'b1, on)
  endtask
  task automatic t_serial();
    u_host.mode(1'b0, 1'b0);
    u_host.shift(8'hff, 3);
    u_host.chips(1'b1, 1'b0);
    u_host.chips(1'b0, 1'b1);
    cmd(8'hae);
    `CHK("panel", 1'b0, on)
    cmd(8'h14);
    cmd(8'h00);
    dat(8'h3c);
    u_host.read(1'b0, q);
    `CHK("serial rd", u_host.bus, q)
    scan(8'h40, 8'h3c);
  endtask
  initial begin
    {rstn, rip, scan_page, scan_col} = '0;
    repeat (8) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    `CHK("oe_n", 1'b1, oe_n)
    t_commands();
    t_data();
    t_deselect();
    t_busy();
    t_serial();
    test_done();
  end
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    test_done();
  end
endmodule
bind lcd_host_interface_decoder lcd_host_properties u_props (
  .sys_clk, .rstn, .chip_select_low_active_n, .chip_select_high_active,
  .interface_kind_select, .parallel_style_select, .data_command_select,
  .enable_or_read_strobe, .rw_or_write_strobe, .data_bus_in,
  .data_bus_out, .data_bus_oe_n, .reset_in_progress_flag, .busy_flag,
  .panel_on_flag, .seg_reverse_flag, .polarity_invert_bit,
  .all_dots_on_bit, .start_line_field, .page_address_field);
